// File: design/fwsr_pkg.sv
package fwsr_pkg;

	// flash pin widths, bit positions and synchroniser depth
	localparam int ADDR_W = 21;
	localparam int DATA_W = 16;
	localparam int SECT_LSB = 12;
	localparam int POLL_BIT = 7;
	localparam int TIMEOUT_BIT = 5;
	localparam int SYNC_STAGES = 2;

	// apb register map
	localparam int APB_AW = 8;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_DATA = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_RDATA = 8'h10;

	// field positions
	localparam int CTRL_NOPOLL = 8;
	localparam int CTRL_GO = 31;
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_FAIL = 2;
	localparam int ST_REFUSED = 3;
	localparam int ST_BYPASS = 4;
	localparam int ST_IDMODE = 5;
	localparam int ST_ERASE = 6;
	localparam int ST_SUSP = 7;
	localparam int ST_READY = 8;
	localparam int ST_PEND = 9;

	// command cycle values
	localparam logic [ADDR_W-1:0] UNLOCK_A1 = 21'h000555;
	localparam logic [ADDR_W-1:0] UNLOCK_A2 = 21'h0002AA;
	localparam logic [DATA_W-1:0] CMD_UNLOCK1 = 16'h00AA;
	localparam logic [DATA_W-1:0] CMD_UNLOCK2 = 16'h0055;
	localparam logic [DATA_W-1:0] CMD_PROGRAM = 16'h00A0;
	localparam logic [DATA_W-1:0] CMD_BYP_ENTER = 16'h0020;
	localparam logic [DATA_W-1:0] CMD_IDENT = 16'h0090;
	localparam logic [DATA_W-1:0] CMD_BYP_EXIT2 = 16'h0000;
	localparam logic [DATA_W-1:0] CMD_ERASE = 16'h0080;
	localparam logic [DATA_W-1:0] CMD_CHIP = 16'h0010;
	localparam logic [DATA_W-1:0] CMD_SECTOR = 16'h0030;
	localparam logic [DATA_W-1:0] CMD_SUSPEND = 16'h00B0;
	localparam logic [DATA_W-1:0] CMD_RESUME = 16'h0030;
	localparam logic [DATA_W-1:0] CMD_RESET = 16'h00F0;

	// bus cycle timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int T_SETUP_NS = 10;
	localparam int T_WPULSE_NS = 40;
	localparam int T_HOLD_NS = 20;
	localparam int T_ACCESS_NS = 100;
	localparam int T_RECOVER_NS = 30;
	localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WPULSE_CYC = (T_WPULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_CYC = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACCESS_CYC = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RECOVER_CYC = (T_RECOVER_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;

	typedef enum logic [3:0] {
		OP_READ, OP_RESET, OP_PROGRAM, OP_BYP_ENTER, OP_BYP_PROG,
		OP_BYP_EXIT, OP_CHIP_ERASE, OP_SECT_ERASE, OP_SUSPEND,
		OP_RESUME, OP_IDENT, OP_POLL
	} fwsr_op_e;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic              rd;
		logic              last;
	} fwsr_step_s;

endpackage

// File: design/fwsr_cyc_if.sv
`timescale 1ns/1ps
interface fwsr_cyc_if;
	import fwsr_pkg::*;
	logic              req;
	logic              wr;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic              done;
	logic [DATA_W-1:0] rdata;
	modport ctl (output req, wr, addr, wdata, input done, rdata);
	modport eng (input req, wr, addr, wdata, output done, rdata);
endinterface

// File: design/fwsr_cycle.sv
`timescale 1ns/1ps
module fwsr_cycle import fwsr_pkg::*; (
	// clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_b_i,
	// cycle requests
	fwsr_cyc_if.eng                cyc,
	input  wire logic [DATA_W-1:0] dq_sync_i,
	// flash pins
	output logic                   ce_n_o,
	output logic                   we_n_o,
	output logic                   oe_n_o,
	output logic [ADDR_W-1:0]      addr_o,
	output logic [DATA_W-1:0]      dq_o,
	output logic                   dq_oe_o
);
	typedef enum logic [2:0] {
		C_IDLE, C_SETUP, C_PULSE, C_HOLD, C_READ, C_REC
	} fwsr_cph_e;

	typedef struct packed {
		fwsr_cph_e         phase;
		logic [7:0]        cnt;
		logic              ce_n;
		logic              we_n;
		logic              oe_n;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dq;
		logic              dq_oe;
		logic              done;
		logic [DATA_W-1:0] rdata;
	} fwsr_cyc_s;

	fwsr_cyc_s s;
	fwsr_cyc_s next_s;

	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		if (s.cnt != 8'h00) begin
			next_s.cnt = s.cnt - 8'h01;
		end else begin
			case (s.phase)
				C_IDLE: begin
					if (cyc.req) begin
						next_s.addr = cyc.addr;
						next_s.ce_n = 1'b0;
						if (cyc.wr) begin
							next_s.dq = cyc.wdata;
							next_s.dq_oe = 1'b1;
							next_s.cnt = 8'(SETUP_CYC - 1);
							next_s.phase = C_SETUP;
						end else begin
							next_s.oe_n = 1'b0;
							// synchroniser delay added to the access time
							next_s.cnt = 8'(ACCESS_CYC + SYNC_STAGES - 1);
							next_s.phase = C_READ;
						end
					end
				end
				C_SETUP: begin
					next_s.we_n = 1'b0;
					next_s.cnt = 8'(WPULSE_CYC - 1);
					next_s.phase = C_PULSE;
				end
				C_PULSE: begin
					next_s.we_n = 1'b1;
					next_s.cnt = 8'(HOLD_CYC - 1);
					next_s.phase = C_HOLD;
				end
				C_HOLD: begin
					next_s.ce_n = 1'b1;
					next_s.dq_oe = 1'b0;
					next_s.cnt = 8'(RECOVER_CYC - 1);
					next_s.phase = C_REC;
				end
				// each read is framed by its own oe pulse so toggles advance
				C_READ: begin
					next_s.rdata = dq_sync_i;
					next_s.oe_n = 1'b1;
					next_s.ce_n = 1'b1;
					next_s.cnt = 8'(RECOVER_CYC - 1);
					next_s.phase = C_REC;
				end
				C_REC: begin
					next_s.done = 1'b1;
					next_s.phase = C_IDLE;
				end
				default: next_s.phase = C_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s <= '{phase: C_IDLE, cnt: 8'h00, ce_n: 1'b1, we_n: 1'b1,
				oe_n: 1'b1, addr: '0, dq: '0, dq_oe: 1'b0, done: 1'b0,
				rdata: '0};
		end else begin
			s <= next_s;
		end
	end

	assign cyc.done = s.done;
	assign cyc.rdata = s.rdata;
	assign ce_n_o = s.ce_n;
	assign we_n_o = s.we_n;
	assign oe_n_o = s.oe_n;
	assign addr_o = s.addr;
	assign dq_o = s.dq;
	assign dq_oe_o = s.dq_oe;
endmodule

// File: design/fwsr_sync.sv
`timescale 1ns/1ps
module fwsr_sync #(
	parameter int W = 17
) (
	input  wire logic         clk_i,
	input  wire logic         rst_b_i,
	input  wire logic [W-1:0] d_i,
	output logic [W-1:0]      q_o
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] q;
	} fwsr_sync_s;

	fwsr_sync_s s;
	fwsr_sync_s next_s;

	if (W < 1) begin : g_chk
		$error("fwsr_sync: W must be at least 1");
	end

	always_comb begin
		next_s.meta = d_i;
		next_s.q = s.meta;
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s <= '{meta: '1, q: '1};
		end else begin
			s <= next_s;
		end
	end

	assign q_o = s.q;
endmodule

// File: design/fwsr_top.sv
`timescale 1ns/1ps
// How it works
// - sector erase carries sector bits only
// - all command cycles writes, identify ends read
// - reset command leaves identify or timeout
// - short program only after bypass entry
// - bypass left only by bypass exit
// - program poll at program address, waits for programmed data bit
// - erase poll reads 0, then 1
// - confirm poll with a further read
module fwsr_top import fwsr_pkg::*; (
	// clock and reset
	input  wire logic              CLK_I,
	input  wire logic              RST_B_I,
	// apb slave
	input  wire logic              PSEL_I,
	input  wire logic              PENABLE_I,
	input  wire logic              PWRITE_I,
	input  wire logic [APB_AW-1:0] PADDR_I,
	input  wire logic [31:0]       PWDATA_I,
	output logic [31:0]            PRDATA_O,
	output logic                   PREADY_O,
	output logic                   PSLVERR_O,
	// flash pins
	output logic                   FL_CE_N_O,
	output logic                   FL_WE_N_O,
	output logic                   FL_OE_N_O,
	output logic [ADDR_W-1:0]      FL_ADDR_O,
	input  wire logic [DATA_W-1:0] FL_DQ_I,
	output logic [DATA_W-1:0]      FL_DQ_O,
	output logic                   FL_DQ_OE_O,
	input  wire logic              READY_BUSY_N_PIN_I
);
	typedef enum logic [2:0] {
		M_IDLE, M_ISSUE, M_WAIT, M_POLL, M_PWAIT, M_RESET, M_RWAIT
	} fwsr_mph_e;

	typedef struct packed {
		fwsr_mph_e         phase;
		fwsr_op_e          op;
		logic              nopoll;
		logic [2:0]        idx;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic              req;
		logic              cyc_wr;
		logic [ADDR_W-1:0] cyc_addr;
		logic [DATA_W-1:0] cyc_wdata;
		logic              done;
		logic              fail;
		logic              refused;
		logic              bypass;
		logic              idmode;
		logic              erase_pend;
		logic              susp;
		logic              pend;
		logic              expect_bit;
		logic              matched;
		logic              to_seen;
		logic [DATA_W-1:0] rdata;
		logic [31:0]       prdata;
		logic              pready;
		logic              pslverr;
	} fwsr_top_s;

	fwsr_top_s         s;
	fwsr_top_s         next_s;
	fwsr_step_s        st;
	logic [DATA_W:0]   synced;
	fwsr_cyc_if        cyc ();

	fwsr_sync #(.W(DATA_W + 1)) u_sync (
		.clk_i   (CLK_I),
		.rst_b_i (RST_B_I),
		.d_i     ({READY_BUSY_N_PIN_I, FL_DQ_I}),
		.q_o     (synced)
	);

	fwsr_cycle u_cycle (
		.clk_i     (CLK_I),
		.rst_b_i   (RST_B_I),
		.cyc       (cyc.eng),
		.dq_sync_i (synced[DATA_W-1:0]),
		.ce_n_o    (FL_CE_N_O),
		.we_n_o    (FL_WE_N_O),
		.oe_n_o    (FL_OE_N_O),
		.addr_o    (FL_ADDR_O),
		.dq_o      (FL_DQ_O),
		.dq_oe_o   (FL_DQ_OE_O)
	);

	function automatic logic mapped(input logic [APB_AW-1:0] a);
		return a == REG_CTRL || a == REG_ADDR || a == REG_DATA ||
			a == REG_STATUS || a == REG_RDATA;
	endfunction

	// one bus cycle of a command sequence
	function automatic fwsr_step_s step_of(input fwsr_op_e op,
			input logic [2:0] idx, input logic [ADDR_W-1:0] a,
			input logic [DATA_W-1:0] d);
		fwsr_step_s r;
		logic [DATA_W-1:0] third;
		r = '{addr: '0, data: '0, rd: 1'b0, last: 1'b0};
		third = CMD_ERASE;
		case (op)
			OP_PROGRAM: third = CMD_PROGRAM;
			OP_BYP_ENTER: third = CMD_BYP_ENTER;
			OP_IDENT: third = CMD_IDENT;
			default: third = CMD_ERASE;
		endcase
		// unused high address bits left zero
		if (idx == 3'd0 || idx == 3'd3) begin
			r.addr = UNLOCK_A1;
			r.data = CMD_UNLOCK1;
		end else if (idx == 3'd1 || idx == 3'd4) begin
			r.addr = UNLOCK_A2;
			r.data = CMD_UNLOCK2;
		end else begin
			r.addr = UNLOCK_A1;
			r.data = third;
		end
		case (op)
			OP_READ: r = '{addr: a, data: '0, rd: 1'b1, last: 1'b1};
			OP_RESET: r = '{addr: '0, data: CMD_RESET, rd: 1'b0, last: 1'b1};
			OP_BYP_ENTER: r.last = (idx == 3'd2);
			// identify sequence ends with a read at the query address
			OP_IDENT: if (idx == 3'd3) begin
				r = '{addr: a, data: '0, rd: 1'b1, last: 1'b1};
			end
			OP_PROGRAM: if (idx == 3'd3) begin
				r = '{addr: a, data: d, rd: 1'b0, last: 1'b1};
			end
			OP_CHIP_ERASE: if (idx == 3'd5) begin
				r = '{addr: UNLOCK_A1, data: CMD_CHIP, rd: 1'b0, last: 1'b1};
			end
			OP_SECT_ERASE: if (idx == 3'd5) begin
				r.addr = {a[ADDR_W-1:SECT_LSB], {SECT_LSB{1'b0}}};
				r.data = CMD_SECTOR;
				r.last = 1'b1;
			end
			OP_BYP_PROG: if (idx == 3'd0) begin
				r = '{addr: '0, data: CMD_PROGRAM, rd: 1'b0, last: 1'b0};
			end else begin
				r = '{addr: a, data: d, rd: 1'b0, last: 1'b1};
			end
			OP_BYP_EXIT: if (idx == 3'd0) begin
				r = '{addr: '0, data: CMD_IDENT, rd: 1'b0, last: 1'b0};
			end else begin
				r = '{addr: '0, data: CMD_BYP_EXIT2, rd: 1'b0, last: 1'b1};
			end
			OP_SUSPEND: r = '{addr: '0, data: CMD_SUSPEND, rd: 1'b0,
				last: 1'b1};
			OP_RESUME: r = '{addr: '0, data: CMD_RESUME, rd: 1'b0,
				last: 1'b1};
			default: r = r;
		endcase
		return r;
	endfunction

	function automatic logic refuse(input fwsr_op_e op, input fwsr_top_s q);
		logic r;
		r = 1'b0;
		case (op)
			OP_BYP_PROG: r = !q.bypass;
			OP_BYP_EXIT: r = !q.bypass;
			OP_PROGRAM: r = q.idmode;
			OP_CHIP_ERASE, OP_SECT_ERASE: r = q.idmode || q.susp ||
				q.erase_pend;
			// suspend only with a chip or sector erase pending
			OP_SUSPEND: r = !q.erase_pend || q.susp;
			OP_RESUME: r = !q.susp;
			OP_POLL: r = !q.pend;
			default: r = 1'b0;
		endcase
		// in bypass only the short program, its exit, read and poll pass
		if (q.bypass && !(op == OP_BYP_PROG || op == OP_BYP_EXIT ||
				op == OP_READ || op == OP_POLL)) begin
			r = 1'b1;
		end
		return r;
	endfunction

	function automatic logic polls(input fwsr_op_e op);
		return op == OP_PROGRAM || op == OP_BYP_PROG ||
			op == OP_CHIP_ERASE || op == OP_SECT_ERASE || op == OP_RESUME;
	endfunction

	always_comb begin
		logic     wr_take;
		logic     go;
		fwsr_op_e new_op;
		wr_take = PSEL_I && PENABLE_I && s.pready && PWRITE_I &&
			!s.pslverr;
		go = 1'b0;
		new_op = fwsr_op_e'(PWDATA_I[3:0]);
		next_s = s;
		next_s.req = 1'b0;
		st = step_of(s.op, s.idx, s.addr, s.data);

		// registered apb answer, one wait state
		next_s.pready = 1'b0;
		next_s.pslverr = 1'b0;
		if (PSEL_I && PENABLE_I && !s.pready) begin
			next_s.pready = 1'b1;
			next_s.pslverr = !mapped(PADDR_I);
			next_s.prdata = 32'h00000000;
			if (!PWRITE_I) begin
				case (PADDR_I)
					REG_CTRL: next_s.prdata = 32'({s.nopoll, 4'h0, s.op});
					REG_ADDR: next_s.prdata = 32'(s.addr);
					REG_DATA: next_s.prdata = 32'(s.data);
					REG_STATUS: next_s.prdata = 32'({s.pend, synced[DATA_W],
						s.susp, s.erase_pend, s.idmode, s.bypass, s.refused,
						s.fail, s.done, s.phase != M_IDLE});
					REG_RDATA: next_s.prdata = 32'(s.rdata);
					default: next_s.prdata = 32'h00000000;
				endcase
			end
		end
		// clears come first so that a hardware set below wins
		if (wr_take) begin
			case (PADDR_I)
				REG_CTRL: go = PWDATA_I[CTRL_GO];
				REG_ADDR: if (s.phase == M_IDLE) begin
					next_s.addr = PWDATA_I[ADDR_W-1:0];
				end else begin
					next_s.refused = 1'b1;
				end
				REG_DATA: if (s.phase == M_IDLE) begin
					next_s.data = PWDATA_I[DATA_W-1:0];
				end else begin
					next_s.refused = 1'b1;
				end
				REG_STATUS: begin
					if (PWDATA_I[ST_DONE]) next_s.done = 1'b0;
					if (PWDATA_I[ST_FAIL]) next_s.fail = 1'b0;
					if (PWDATA_I[ST_REFUSED]) next_s.refused = 1'b0;
				end
				default: next_s.refused = s.refused;
			endcase
		end

		case (s.phase)
			M_IDLE: if (go) begin
				if (s.phase != M_IDLE || refuse(new_op, s)) begin
					next_s.refused = 1'b1;
				end else begin
					next_s.op = new_op;
					next_s.nopoll = PWDATA_I[CTRL_NOPOLL];
					next_s.idx = 3'd0;
					next_s.phase = (new_op == OP_POLL) ? M_POLL : M_ISSUE;
					case (new_op)
						OP_PROGRAM, OP_BYP_PROG: begin
							next_s.pend = 1'b1;
							next_s.expect_bit = s.data[POLL_BIT];
						end
						OP_CHIP_ERASE, OP_SECT_ERASE: begin
							next_s.pend = 1'b1;
							next_s.expect_bit = 1'b1;
							next_s.erase_pend = 1'b1;
						end
						OP_RESUME: begin
							next_s.pend = 1'b1;
							next_s.expect_bit = 1'b1;
							next_s.susp = 1'b0;
						end
						OP_SUSPEND: next_s.susp = 1'b1;
						OP_BYP_ENTER: next_s.bypass = 1'b1;
						OP_BYP_EXIT: next_s.bypass = 1'b0;
						OP_IDENT: next_s.idmode = 1'b1;
						OP_RESET: begin
							next_s.idmode = 1'b0;
							next_s.pend = 1'b0;
						end
						default: next_s.pend = s.pend;
					endcase
				end
			end
			M_ISSUE: begin
				next_s.req = 1'b1;
				next_s.cyc_wr = !st.rd;
				next_s.cyc_addr = st.addr;
				// upper data byte zero in commands
				next_s.cyc_wdata = st.data;
				next_s.phase = M_WAIT;
			end
			M_WAIT: if (cyc.done) begin
				if (st.rd) next_s.rdata = cyc.rdata;
				if (!st.last) begin
					next_s.idx = s.idx + 3'd1;
					next_s.phase = M_ISSUE;
				end else if (polls(s.op) && !s.nopoll) begin
					next_s.phase = M_POLL;
				end else begin
					next_s.done = 1'b1;
					next_s.phase = M_IDLE;
				end
			end
			// poll read at the program or sector address
			M_POLL: begin
				next_s.req = 1'b1;
				next_s.cyc_wr = 1'b0;
				next_s.cyc_addr = s.addr;
				next_s.phase = M_PWAIT;
			end
			M_PWAIT: if (cyc.done) begin
				next_s.rdata = cyc.rdata;
				next_s.phase = M_POLL;
				if (cyc.rdata[POLL_BIT] == s.expect_bit) begin
					next_s.matched = 1'b1;
					// second matching read before trusting data
					if (s.matched) begin
						next_s.matched = 1'b0;
						next_s.to_seen = 1'b0;
						next_s.pend = 1'b0;
						if (!s.susp) next_s.erase_pend = 1'b0;
						next_s.done = 1'b1;
						next_s.phase = M_IDLE;
					end
				end else begin
					next_s.matched = 1'b0;
					if (cyc.rdata[TIMEOUT_BIT]) begin
						next_s.to_seen = 1'b1;
						if (s.to_seen) begin
							next_s.fail = 1'b1;
							next_s.phase = M_RESET;
						end
					end
				end
			end
			// reset after a timed out operation
			M_RESET: begin
				next_s.req = 1'b1;
				next_s.cyc_wr = 1'b1;
				next_s.cyc_addr = '0;
				next_s.cyc_wdata = CMD_RESET;
				next_s.phase = M_RWAIT;
			end
			M_RWAIT: if (cyc.done) begin
				next_s.to_seen = 1'b0;
				next_s.pend = 1'b0;
				if (!s.susp) next_s.erase_pend = 1'b0;
				next_s.done = 1'b1;
				next_s.phase = M_IDLE;
			end
			default: next_s.phase = M_IDLE;
		endcase
	end

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			s <= '{phase: M_IDLE, op: OP_READ, idx: 3'd0, addr: '0,
				data: '0, cyc_addr: '0, cyc_wdata: '0, rdata: '0,
				prdata: 32'h00000000, default: 1'b0};
		end else begin
			s <= next_s;
		end
	end

	assign cyc.req = s.req;
	assign cyc.wr = s.cyc_wr;
	assign cyc.addr = s.cyc_addr;
	assign cyc.wdata = s.cyc_wdata;
	assign PRDATA_O = s.prdata;
	assign PREADY_O = s.pready;
	assign PSLVERR_O = s.pslverr;
endmodule

// File: sim/fwsr_props.sv
`timescale 1ns/1ps
module fwsr_props import fwsr_pkg::*; (
	// clock and reset
	input  wire logic              CLK_I,
	input  wire logic              RST_B_I,
	// apb
	input  wire logic              PSEL_I,
	input  wire logic              PENABLE_I,
	input  wire logic              PREADY_O,
	input  wire logic              PSLVERR_O,
	// flash pins
	input  wire logic              FL_CE_N_O,
	input  wire logic              FL_WE_N_O,
	input  wire logic              FL_OE_N_O,
	input  wire logic [ADDR_W-1:0] FL_ADDR_O,
	input  wire logic [DATA_W-1:0] FL_DQ_O,
	input  wire logic              FL_DQ_OE_O
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RST_B_I);

	a_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
		else $error("pready held over one cycle");
	a_one_wait: assert property (
		$rose(PENABLE_I) && PSEL_I |-> !PREADY_O ##1 PREADY_O)
		else $error("apb wait state wrong");
	a_err_framed: assert property (PSLVERR_O |-> PREADY_O)
		else $error("pslverr without pready");
	a_write_frame: assert property (
		!FL_WE_N_O |-> !FL_CE_N_O && FL_OE_N_O && FL_DQ_OE_O)
		else $error("write strobe outside write frame");
	a_strobe_width: assert property (
		$fell(FL_WE_N_O) |-> !FL_WE_N_O[*5] ##1 FL_WE_N_O)
		else $error("write strobe width wrong");
	a_addr_held: assert property (
		!FL_CE_N_O && $past(!FL_CE_N_O) |-> $stable(FL_ADDR_O))
		else $error("address moved inside cycle");
	a_data_held: assert property (
		$rose(FL_WE_N_O) |-> $stable(FL_DQ_O) ##1
		(FL_DQ_OE_O && $stable(FL_DQ_O))[*2])
		else $error("data not held past strobe rise");
	a_read_frame: assert property (
		!FL_OE_N_O |-> !FL_DQ_OE_O && !FL_CE_N_O && FL_WE_N_O)
		else $error("read frame wrong");
	a_read_len: assert property ($fell(FL_OE_N_O) |-> (!FL_OE_N_O)[*8])
		else $error("read access too short");
	a_cycle_gap: assert property ($rose(FL_CE_N_O) |-> FL_CE_N_O[*2])
		else $error("no recovery gap");

	c_write: cover property ($fell(FL_WE_N_O));
	c_read: cover property ($fell(FL_OE_N_O));
	c_slverr: cover property (PSLVERR_O);
endmodule

bind fwsr_top fwsr_props u_fwsr_props (
	.CLK_I(CLK_I), .RST_B_I(RST_B_I), .PSEL_I(PSEL_I),
	.PENABLE_I(PENABLE_I), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
	.FL_CE_N_O(FL_CE_N_O), .FL_WE_N_O(FL_WE_N_O), .FL_OE_N_O(FL_OE_N_O),
	.FL_ADDR_O(FL_ADDR_O), .FL_DQ_O(FL_DQ_O), .FL_DQ_OE_O(FL_DQ_OE_O)
);

// File: sim/fwsr_flash_model.sv
`timescale 1ns/1ps
module fwsr_flash_model import fwsr_pkg::*; #(
	parameter logic       LOCKED    = 1'h1,
	parameter logic [8:0] PROT_SECT = 9'h1F0
) (
	// flash pins
	input  wire logic              ce_n_i,
	input  wire logic              we_n_i,
	input  wire logic              oe_n_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [DATA_W-1:0] dq_i,
	output logic [DATA_W-1:0]      dq_o,
	output logic                   rb_low_o
);
	logic [DATA_W-1:0] mem [int];
	logic [ADDR_W-1:0] la, pa;
	logic [DATA_W-1:0] pd, out = 16'h0, last = 16'h0;
	logic [8:0]        es;
	logic              busy = 0, ers = 0, arm = 0, byp = 0;
	logic              idm = 0, susp = 0, tmo = 0, t1 = 0, t2 = 0;
	int                st = 0, cnt = 0;
	wire               wstb = ce_n_i | we_n_i;
	wire               rstb = ce_n_i | oe_n_i;

	function automatic logic [DATA_W-1:0] rd(input logic [ADDR_W-1:0] a);
		return mem.exists(int'(a)) ? mem[int'(a)] : 16'hFFFF;
	endfunction

	always @(negedge wstb) la = addr_i;

	always @(posedge wstb) begin
		logic [7:0]  d;
		logic [10:0] a;
		d = dq_i[7:0];
		a = la[10:0];
		if (st == 3) begin
			pa = la;
			pd = dq_i;
			// programming a one over a zero runs out of pulses
			tmo = |(~rd(la) & dq_i);
			busy = 1'h1;
			cnt = 3;
			st = 0;
		end else if (st == 5) begin
			byp = (d != 8'h00);
			st = 0;
		end else if (st == 2) begin
			st = 0;
			case (d)
			8'hA0: st = 3;
			8'h20: byp = 1'h1;
			8'h90: idm = 1'h1;
			8'h80: arm = 1'h1;
			8'h30: if (arm) begin
				es = la[20:12];
				ers = 1'h1;
				busy = 1'h1;
				cnt = 4;
				arm = 1'h0;
			end
			default: ;
			endcase
		end else if (d == 8'hF0) begin
			idm = 1'h0;
			busy = busy & ~tmo;
			tmo = 1'h0;
		end else if (d == 8'hB0 && busy && ers) susp = 1'h1;
		else if (d == 8'h30 && susp) susp = 1'h0;
		else if (byp && d == 8'hA0) st = 3;
		else if (byp && d == 8'h90) st = 5;
		else if (a == 11'h555 && d == 8'hAA) st = 1;
		else if (st == 1 && a == 11'h2AA && d == 8'h55) st = 2;
		else st = 0;
	end

	always @(negedge rstb) begin
		if (busy && !susp && !tmo) begin
			cnt = cnt - 1;
			t1 = ~t1;
		end
		if (busy && cnt == 0) begin
			busy = 1'h0;
			if (ers && es != PROT_SECT) begin
				foreach (mem[k]) if (k[20:12] == es) mem[k] = 16'hFFFF;
			end else if (!ers && pa[20:12] != PROT_SECT) begin
				mem[int'(pa)] = pd;
			end
			ers = 1'h0;
		end
		if (busy && ers && addr_i[20:12] == es) begin
			t2 = ~t2;
			out = {8'h00, susp, t1, 3'h1, t2, 2'h0};
		end else if (busy && !susp) out = {8'h00, ~pd[7] & ~ers, t1, tmo, 5'h0};
		else if (idm && addr_i[7:0] == 8'h03)
			out = LOCKED ? 16'h0099 : 16'h0019;
		else if (idm && addr_i[7:0] == 8'h02)
			out = {15'h0, addr_i[20:12] == PROT_SECT};
		else out = rd(addr_i);
	end

	// released bus shows the inverse of the last word
	always @(posedge rstb) last = out;
	assign dq_o = rstb ? ~last : out;
	assign rb_low_o = busy & ~susp;
endmodule

// File: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top import fwsr_pkg::*; ;
	localparam logic [8:0] PROT = 9'h1F0;
	logic              clk = 0, rst_b = 0, psel = 0, pen = 0, pwr = 0;
	logic [7:0]        paddr = 8'h0;
	logic [31:0]       pwdata = 32'h0, prdata, rdat;
	logic              pready, pslverr, rerr, ce_n, we_n, oe_n, dq_oe, rb_low;
	logic [ADDR_W-1:0] fa, a0, a1;
	logic [DATA_W-1:0] hdq, mdq, d0, d1;
	wire  [DATA_W-1:0] bus = dq_oe ? hdq : mdq;
	int                mismatches = 0, comparisons = 0;
	int                ref_mem [int];
	logic [ADDR_W-1:0] ida [3] = '{21'h000003, {PROT, 12'h002}, 21'h000002};
	logic [7:0]        idd [3] = '{8'h99, 8'h01, 8'h00};

	always #4 clk = ~clk;

	fwsr_top u_fwsr_top (.CLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel),
		.PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
		.PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
		.FL_CE_N_O(ce_n), .FL_WE_N_O(we_n), .FL_OE_N_O(oe_n), .FL_ADDR_O(fa),
		.FL_DQ_I(bus), .FL_DQ_O(hdq), .FL_DQ_OE_O(dq_oe),
		.READY_BUSY_N_PIN_I(~rb_low));
	fwsr_flash_model #(.PROT_SECT(PROT)) u_fwsr_flash_model (.ce_n_i(ce_n),
		.we_n_i(we_n), .oe_n_i(oe_n), .addr_i(fa), .dq_i(bus), .dq_o(mdq),
		.rb_low_o(rb_low));

	task automatic stop_test;
		if (mismatches == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic ck(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'h1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'h1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'h1 && n < 50);
		if (n >= 50) mismatches++;
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'h0;
		pen <= 1'h0;
	endtask

	task automatic op(input fwsr_op_e o, input logic np);
		int n;
		apb(1'h1, REG_STATUS, 32'h0000000E);
		apb(1'h1, REG_CTRL, {1'h1, 22'h0, np, 4'h0, 4'(o)});
		n = 0;
		do begin
			apb(1'h0, REG_STATUS, 32'h0);
			n++;
		end while (rdat[ST_BUSY] !== 1'h0 && n < 400);
		if (n >= 400) mismatches++;
	endtask

	task automatic st(input logic [31:0] m, input logic [31:0] e);
		apb(1'h0, REG_STATUS, 32'h0);
		ck(rdat & m, e);
	endtask

	task automatic rd_at(input logic [ADDR_W-1:0] a);
		apb(1'h1, REG_ADDR, 32'(a));
		op(OP_READ, 1'h0);
		apb(1'h0, REG_RDATA, 32'h0);
		ck(rdat, ref_mem.exists(int'(a)) ? 32'(ref_mem[int'(a)])
			: 32'h0000FFFF);
	endtask

	task automatic prog(input logic [ADDR_W-1:0] a, input logic [15:0] d,
		input fwsr_op_e o, input logic np);
		apb(1'h1, REG_ADDR, 32'(a));
		apb(1'h1, REG_DATA, 32'(d));
		op(o, np);
	endtask

	initial begin
		#400000;
		mismatches++;
		stop_test;
	end

	initial begin
		void'($urandom(84977));
		a0 = {1'h0, 20'($urandom)};
		a1 = a0 ^ {8'h0, 1'h1, 12'($urandom)};
		d0 = 16'($urandom) & 16'hFFFE;
		d1 = 16'($urandom) & 16'hFFFE;
		repeat (16) @(posedge clk);
		rst_b <= 1'h1;
		apb(1'h0, REG_CTRL, 32'h0);
		ck(rdat, 32'h0);
		apb(1'h0, 8'h20, 32'h0);
		ck({rdat[30:0], rerr}, 32'h1);
		st(32'h3FF, 32'h100);
		prog(a0, d0, OP_PROGRAM, 1'h1);
		st(32'h100, 32'h0);
		op(OP_POLL, 1'h0);
		st(32'h107, 32'h102);
		ref_mem[int'(a0)] = d0;
		rd_at(a0);
		prog(a1, d1, OP_BYP_PROG, 1'h0);
		st(32'h18, 32'h8);
		op(OP_BYP_ENTER, 1'h0);
		prog(a1, d1, OP_BYP_PROG, 1'h0);
		st(32'h17, 32'h12);
		ref_mem[int'(a1)] = d1;
		op(OP_BYP_EXIT, 1'h0);
		st(32'h10, 32'h0);
		rd_at(a1);
		apb(1'h1, REG_ADDR, 32'(a0));
		op(OP_SECT_ERASE, 1'h1);
		op(OP_SUSPEND, 1'h0);
		st(32'h188, 32'h180);
		rd_at(a1);
		apb(1'h1, REG_ADDR, 32'(a0));
		op(OP_RESUME, 1'h1);
		st(32'h88, 32'h0);
		op(OP_RESUME, 1'h0);
		st(32'h88, 32'h8);
		op(OP_POLL, 1'h0);
		st(32'h147, 32'h102);
		foreach (ref_mem[k]) if (k[20:12] == a0[20:12]) ref_mem[k] = 16'hFFFF;
		rd_at(a0);
		rd_at(a1);
		prog(a1, d1 | 16'h0001, OP_PROGRAM, 1'h0);
		st(32'h107, 32'h106);
		rd_at(a1);
		for (int i = 0; i < 3; i++) begin
			apb(1'h1, REG_ADDR, 32'(ida[i]));
			op(OP_IDENT, 1'h0);
			st(32'h20, 32'h20);
			apb(1'h0, REG_RDATA, 32'h0);
			ck(rdat & 32'hFF, 32'(idd[i]));
			op(OP_RESET, 1'h0);
			st(32'h20, 32'h0);
		end
		stop_test;
	end
endmodule
